// [core/serial_flash_command_front_end.sv]
// serial flash command front end: link-side framing and decode, system-side command report
`timescale 1ns/1ps

// Summary of operation
// [R01] mode 0/3: sample rising, drive falling
// [R02] dual modes turn pins around
// [R03] host sends chip select, opcode, operands
// [R04] all bytes travel msb first
// [R05] chip select release ends the frame
// [R06] unknown opcode: ignore until next frame
// [R07] early release: nothing done, back idle
// [R08] 24-bit address, top two bits dropped
// [R09] opcode 1Bh: two dummy bytes
// [R10] 0Bh one dummy, 03h none
// [R11] host picks read opcode by clock
// [R12] stream array data, address auto-increments
// [R13] wrap to zero with no gap
// [R14] release mid-byte stops output immediately
// [R15] 3Bh: address, one dummy, two bits/clock
// [R16] dual read: pairs 7/6, 5/4 per clock
// [R17] 02h/A2h: address then data bytes
// [R18] block erases: address only
// [R19] chip erase, suspend, resume: opcode only
// [R20] write enable/disable: opcode only
// [R21] 3Ch: address then returned data
// [R22] 33h/34h one byte in; 35h reads
// [R23] 9Bh programs, 77h reads two dummies
// [R24] 05h reads; 01h/31h take one byte
// [R25] F0h one byte; 9Fh returns 1-4 bytes
// [R26] B9h/ABh: opcode only
module serial_flash_command_front_end (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   input wire logic sck_in,
   input wire logic cs_n_in,
   input wire logic serial_in_in,
   input wire logic output_turned_input_pin_in,
   output logic serial_out_out,
   output logic serial_out_oe_out,
   output logic input_turned_output_pin_out,
   output logic input_turned_output_pin_oe_out,
   output logic rd_en_out,
   output sflash_pkg::space_e rd_space_out,
   output logic [sflash_pkg::ADDR_W-1:0] rd_addr_out,
   input wire logic [7:0] rd_data_in,
   output logic cmd_valid_out,
   output logic [7:0] cmd_opcode_out,
   output logic [sflash_pkg::ADDR_W-1:0] cmd_addr_out,
   output logic wr_valid_out,
   output logic [7:0] wr_data_out,
   output logic frame_end_out,
   output logic frame_aligned_out
);
   import sflash_pkg::*;

   // ==========================================================================
   // link-side types
   typedef enum logic [2:0] {
      ST_OPCODE = 3'b000,
      ST_ADDR = 3'b001,
      ST_DUMMY = 3'b010,
      ST_DIN = 3'b011,
      ST_DOUT = 3'b100,
      ST_IGNORE = 3'b101
   } rx_state_e;

   // cleared by every chip select release
   typedef struct packed {
      rx_state_e state;
      logic [2:0] bit_cnt;
      logic [1:0] byte_cnt;
      logic [7:0] sh;
      // sh is reused for the address bytes
      logic [7:0] opcode;
      cmd_info_s info;
      logic [ADDR_W-1:0] addr;
   } frame_s;

   // survives chip select so toggles never flip spuriously
   typedef struct packed {
      logic cmd_tgl;
      logic wr_tgl;
      logic frag;
      logic [7:0] hdr_opcode;
      logic [ADDR_W-1:0] hdr_addr;
      logic [7:0] wr_byte;
   } link_hold_s;

   // ==========================================================================
   // system-side types
   typedef struct packed {
      logic cs_seen;
      logic cmd_seen;
      logic wr_seen;
      logic cmd_valid;
      logic [7:0] cmd_opcode;
      logic [ADDR_W-1:0] cmd_addr;
      logic wr_valid;
      logic [7:0] wr_data;
      logic frame_end;
      logic frame_aligned;
   } sys_s;

   localparam logic [3:0] SYNC_RST = 4'h1;

   function automatic rx_state_e after_header(input cmd_info_s i);
      rx_state_e s;
      if (i.dummy != 2'h0)
         s = ST_DUMMY;
      else if (i.dir == DIR_OUT)
         s = ST_DOUT; // [R12]
      else if (i.dir == DIR_IN)
         s = ST_DIN;
      else
         s = ST_IGNORE; // [R18] [R19] [R20] [R26]
      return s;
   endfunction

   frame_s fr_ff;
   frame_s nxt_fr;
   link_hold_s hold_ff;
   link_hold_s nxt_hold;
   sys_s sys_ff;
   sys_s nxt_sys;

   logic link_rst_n;
   logic dual_phase;
   logic [2:0] step;
   logic [3:0] cnt_sum;
   logic byte_done;
   logic [7:0] byte_in;
   cmd_info_s dec;
   logic [ADDR_W-1:0] addr_shift;
   logic [3:0] sync_q;

   // ==========================================================================
   // link framing: deasserted chip select holds the frame logic in reset
   assign link_rst_n = rst_n_in & ~cs_n_in; // [R05] [R07]

   always_comb
   begin
      nxt_fr = fr_ff;
      nxt_hold = hold_ff;

      dual_phase = fr_ff.info.dual && (fr_ff.state == ST_DIN || fr_ff.state == ST_DOUT);
      step = dual_phase ? BIT_STEP_DUAL : BIT_STEP_SINGLE;
      cnt_sum = {1'b0, fr_ff.bit_cnt} + {1'b0, step};
      byte_done = cnt_sum[3];
      // dual input: msb arrives on the turned-around output pin
      if (dual_phase && fr_ff.state == ST_DIN)
         byte_in = {fr_ff.sh[5:0], output_turned_input_pin_in, serial_in_in}; // [R02]
      else
         byte_in = {fr_ff.sh[6:0], serial_in_in}; // [R04]
      dec = decode_opcode(byte_in);
      addr_shift = {fr_ff.addr[ADDR_W-9:0], byte_in}; // [R08]

      nxt_fr.bit_cnt = cnt_sum[2:0];
      nxt_fr.sh = byte_in;
      case (fr_ff.state)
         ST_OPCODE:
         begin
            if (byte_done)
            begin
               nxt_fr.info = dec;
               nxt_fr.opcode = byte_in;
               nxt_fr.byte_cnt = BYTE_CNT_RST;
               if (!dec.known)
                  nxt_fr.state = ST_IGNORE; // [R06]
               else if (dec.has_addr)
                  nxt_fr.state = ST_ADDR; // [R17] [R21] [R22] [R23]
               else
               begin
                  nxt_hold.cmd_tgl = ~hold_ff.cmd_tgl; // [R19] [R20] [R24] [R25] [R26]
                  nxt_hold.hdr_opcode = byte_in;
                  nxt_hold.hdr_addr = ADDR_RST;
                  nxt_fr.addr = ADDR_RST;
                  nxt_fr.state = after_header(dec);
               end
            end
         end

         ST_ADDR:
         begin
            if (byte_done)
            begin
               nxt_fr.addr = addr_shift;
               nxt_fr.byte_cnt = fr_ff.byte_cnt + 2'h1;
               if (fr_ff.byte_cnt == ADDR_LAST_BYTE)
               begin
                  // report only once opcode and full address are in
                  nxt_hold.cmd_tgl = ~hold_ff.cmd_tgl; // [R07]
                  nxt_hold.hdr_opcode = fr_ff.opcode;
                  nxt_hold.hdr_addr = addr_shift;
                  nxt_fr.byte_cnt = BYTE_CNT_RST;
                  nxt_fr.state = after_header(fr_ff.info);
               end
            end
         end

         // dummy bits are counted, not kept
         ST_DUMMY:
         begin
            if (byte_done)
            begin
               nxt_fr.byte_cnt = fr_ff.byte_cnt + 2'h1;
               if (fr_ff.byte_cnt + 2'h1 == fr_ff.info.dummy)
               begin
                  nxt_fr.byte_cnt = BYTE_CNT_RST;
                  nxt_fr.state = ST_DOUT; // [R09] [R10] [R15] [R23]
               end
            end
         end

         // a byte cut by release is dropped
         ST_DIN:
         begin
            if (byte_done)
            begin
               nxt_hold.wr_tgl = ~hold_ff.wr_tgl; // [R17]
               nxt_hold.wr_byte = byte_in;
               if (fr_ff.info.one_byte)
                  nxt_fr.state = ST_IGNORE; // [R22] [R24] [R25]
            end
         end

         ST_DOUT:
         begin
            if (byte_done)
            begin
               // natural rollover of the counter gives the seamless wrap
               nxt_fr.addr = fr_ff.addr + ADDR_ONE; // [R12] [R13]
               nxt_fr.byte_cnt = fr_ff.byte_cnt + 2'h1;
               if (fr_ff.info.id_limit && fr_ff.byte_cnt == ID_LAST_BYTE)
                  nxt_fr.state = ST_IGNORE; // [R25]
            end
         end

         ST_IGNORE:
         begin
            nxt_fr.bit_cnt = BIT_CNT_RST;
         end

         // illegal state parks until release
         default:
         begin
            nxt_fr.state = ST_IGNORE;
         end
      endcase

      nxt_hold.frag = (nxt_fr.state == ST_DIN) && (nxt_fr.bit_cnt != BIT_CNT_RST);
   end

   always_ff @(posedge sck_in or negedge link_rst_n) // [R01]
   begin
      if (!link_rst_n)
         fr_ff <= '0;
      else
         fr_ff <= nxt_fr;
   end

   always_ff @(posedge sck_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         hold_ff <= '0;
      else
         hold_ff <= nxt_hold;
   end

   // ==========================================================================
   // read port and output stage
   // read data must settle within half a link clock period after rd_addr_out moves
   assign rd_en_out = (fr_ff.state == ST_DOUT);
   assign rd_space_out = fr_ff.info.space;
   assign rd_addr_out = fr_ff.addr;

   serial_out_stage u_out (
      .sck_in(sck_in),
      .link_rst_n_in(link_rst_n),
      .active_in(fr_ff.state == ST_DOUT),
      .load_in(fr_ff.bit_cnt == BIT_CNT_RST),
      .dual_in(fr_ff.info.dual),
      .data_in(rd_data_in),
      .so_out(serial_out_out),
      .so_oe_out(serial_out_oe_out),
      .sio_out(input_turned_output_pin_out),
      .sio_oe_out(input_turned_output_pin_oe_out)
   );

   // ==========================================================================
   // crossing to the system clock
   // the link clock stops between frames, so frame end is taken from chip select here
   flash_sync3 #(
      .W(4),
      .RST_VAL(SYNC_RST)
   ) u_sync (
      .clk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .en_in(clk_en_in),
      .d_in({hold_ff.frag, hold_ff.wr_tgl, hold_ff.cmd_tgl, cs_n_in}),
      .q_out(sync_q)
   );

   always_comb
   begin
      nxt_sys = sys_ff;
      if (clk_en_in)
      begin
         nxt_sys.cs_seen = sync_q[0];
         nxt_sys.cmd_seen = sync_q[1];
         nxt_sys.wr_seen = sync_q[2];
         // held words are stable for a full byte time after their toggle
         nxt_sys.cmd_valid = sync_q[1] ^ sys_ff.cmd_seen;
         nxt_sys.wr_valid = sync_q[2] ^ sys_ff.wr_seen;
         if (sync_q[1] ^ sys_ff.cmd_seen)
         begin
            nxt_sys.cmd_opcode = hold_ff.hdr_opcode;
            nxt_sys.cmd_addr = hold_ff.hdr_addr;
         end
         if (sync_q[2] ^ sys_ff.wr_seen)
            nxt_sys.wr_data = hold_ff.wr_byte;
         nxt_sys.frame_end = sync_q[0] & ~sys_ff.cs_seen; // [R05]
         if (sync_q[0] & ~sys_ff.cs_seen)
            nxt_sys.frame_aligned = ~sync_q[3];
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         sys_ff <= '{cs_seen: 1'b1, default: '0};
      else
         sys_ff <= nxt_sys;
   end

   assign cmd_valid_out = sys_ff.cmd_valid;
   assign cmd_opcode_out = sys_ff.cmd_opcode;
   assign cmd_addr_out = sys_ff.cmd_addr;
   assign wr_valid_out = sys_ff.wr_valid;
   assign wr_data_out = sys_ff.wr_data;
   assign frame_end_out = sys_ff.frame_end;
   assign frame_aligned_out = sys_ff.frame_aligned;
endmodule

// [inc/sflash_pkg.sv]
// shared constants, types and opcode decoding for the serial flash command front end
package sflash_pkg;

   // ==========================================================================
   // widths and counts
   localparam int ADDR_W = 22;
   localparam int BYTE_W = 8;
   localparam logic [2:0] BIT_STEP_SINGLE = 3'h1;
   localparam logic [2:0] BIT_STEP_DUAL = 3'h2;
   localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
   localparam logic [1:0] ID_LAST_BYTE = 2'h3;
   localparam logic [2:0] BIT_CNT_RST = 3'h0;
   localparam logic [1:0] BYTE_CNT_RST = 2'h0;
   localparam logic [ADDR_W-1:0] ADDR_RST = 22'h000000;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 22'h000001;

   // ==========================================================================
   // opcodes
   localparam logic [7:0] OPC_READ_MAX = 8'h1b;
   localparam logic [7:0] OPC_READ_FAST = 8'h0b;
   localparam logic [7:0] OPC_READ_SLOW = 8'h03;
   localparam logic [7:0] OPC_READ_DUAL = 8'h3b;
   localparam logic [7:0] OPC_ERASE_4K = 8'h20;
   localparam logic [7:0] OPC_ERASE_32K = 8'h52;
   localparam logic [7:0] OPC_ERASE_64K = 8'hd8;
   localparam logic [7:0] OPC_CHIP_ERASE_A = 8'h60;
   localparam logic [7:0] OPC_CHIP_ERASE_B = 8'hc7;
   localparam logic [7:0] OPC_PROGRAM = 8'h02;
   localparam logic [7:0] OPC_PROGRAM_DUAL = 8'ha2;
   localparam logic [7:0] OPC_SUSPEND = 8'hb0;
   localparam logic [7:0] OPC_RESUME = 8'hd0;
   localparam logic [7:0] OPC_WRITE_EN = 8'h06;
   localparam logic [7:0] OPC_WRITE_DIS = 8'h04;
   localparam logic [7:0] OPC_PROTECT = 8'h36;
   localparam logic [7:0] OPC_UNPROTECT = 8'h39;
   localparam logic [7:0] OPC_READ_PROT = 8'h3c;
   localparam logic [7:0] OPC_LOCKDOWN = 8'h33;
   localparam logic [7:0] OPC_FREEZE_LOCK = 8'h34;
   localparam logic [7:0] OPC_READ_LOCK = 8'h35;
   localparam logic [7:0] OPC_PROGRAM_OTP = 8'h9b;
   localparam logic [7:0] OPC_READ_OTP = 8'h77;
   localparam logic [7:0] OPC_READ_STATUS = 8'h05;
   localparam logic [7:0] OPC_WRITE_STAT1 = 8'h01;
   localparam logic [7:0] OPC_WRITE_STAT2 = 8'h31;
   localparam logic [7:0] OPC_SOFT_RESET = 8'hf0;
   localparam logic [7:0] OPC_READ_ID = 8'h9f;
   localparam logic [7:0] OPC_POWER_DOWN = 8'hb9;
   localparam logic [7:0] OPC_POWER_UP = 8'hab;

   // ==========================================================================
   // command shape
   typedef enum logic [1:0] {
      DIR_NONE = 2'b00,
      DIR_IN = 2'b01,
      DIR_OUT = 2'b10
   } dir_e;

   typedef enum logic [2:0] {
      SPACE_ARRAY = 3'b000,
      SPACE_STATUS = 3'b001,
      SPACE_ID = 3'b010,
      SPACE_PROT = 3'b011,
      SPACE_LOCK = 3'b100,
      SPACE_OTP = 3'b101
   } space_e;

   typedef struct packed {
      logic known;
      logic has_addr;
      logic [1:0] dummy;
      dir_e dir;
      logic dual;
      logic one_byte;
      logic id_limit;
      space_e space;
   } cmd_info_s;

   function automatic cmd_info_s shape(input logic a, input logic [1:0] d, input dir_e r,
                                       input logic du, input logic ob, input space_e s);
      cmd_info_s i;
      i.known = 1'b1;
      i.has_addr = a;
      i.dummy = d;
      i.dir = r;
      i.dual = du;
      i.one_byte = ob;
      i.id_limit = (s == SPACE_ID);
      i.space = s;
      return i;
   endfunction

   function automatic cmd_info_s decode_opcode(input logic [7:0] opc);
      cmd_info_s i;
      i = '0;
      case (opc)
         OPC_READ_MAX: i = shape(1'b1, 2'h2, DIR_OUT, 1'b0, 1'b0, SPACE_ARRAY);
         OPC_READ_FAST: i = shape(1'b1, 2'h1, DIR_OUT, 1'b0, 1'b0, SPACE_ARRAY);
         OPC_READ_SLOW: i = shape(1'b1, 2'h0, DIR_OUT, 1'b0, 1'b0, SPACE_ARRAY);
         OPC_READ_DUAL: i = shape(1'b1, 2'h1, DIR_OUT, 1'b1, 1'b0, SPACE_ARRAY);
         OPC_ERASE_4K, OPC_ERASE_32K, OPC_ERASE_64K, OPC_PROTECT, OPC_UNPROTECT:
            i = shape(1'b1, 2'h0, DIR_NONE, 1'b0, 1'b0, SPACE_ARRAY);
         OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B, OPC_SUSPEND, OPC_RESUME, OPC_WRITE_EN,
         OPC_WRITE_DIS, OPC_POWER_DOWN, OPC_POWER_UP:
            i = shape(1'b0, 2'h0, DIR_NONE, 1'b0, 1'b0, SPACE_ARRAY);
         OPC_PROGRAM: i = shape(1'b1, 2'h0, DIR_IN, 1'b0, 1'b0, SPACE_ARRAY);
         OPC_PROGRAM_DUAL: i = shape(1'b1, 2'h0, DIR_IN, 1'b1, 1'b0, SPACE_ARRAY);
         OPC_READ_PROT: i = shape(1'b1, 2'h0, DIR_OUT, 1'b0, 1'b0, SPACE_PROT);
         OPC_LOCKDOWN, OPC_FREEZE_LOCK:
            i = shape(1'b1, 2'h0, DIR_IN, 1'b0, 1'b1, SPACE_LOCK);
         OPC_READ_LOCK: i = shape(1'b1, 2'h0, DIR_OUT, 1'b0, 1'b0, SPACE_LOCK);
         OPC_PROGRAM_OTP: i = shape(1'b1, 2'h0, DIR_IN, 1'b0, 1'b0, SPACE_OTP);
         OPC_READ_OTP: i = shape(1'b1, 2'h2, DIR_OUT, 1'b0, 1'b0, SPACE_OTP);
         OPC_READ_STATUS: i = shape(1'b0, 2'h0, DIR_OUT, 1'b0, 1'b0, SPACE_STATUS);
         OPC_WRITE_STAT1, OPC_WRITE_STAT2, OPC_SOFT_RESET:
            i = shape(1'b0, 2'h0, DIR_IN, 1'b0, 1'b1, SPACE_STATUS);
         OPC_READ_ID: i = shape(1'b0, 2'h0, DIR_OUT, 1'b0, 1'b0, SPACE_ID);
         default: i = '0;
      endcase
      return i;
   endfunction

endpackage

// [core/flash_sync3.sv]
// three-stage synchroniser whose output follows once stages two and three agree
`timescale 1ns/1ps
module flash_sync3 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic en_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sync_s;

   sync_s st_ff;
   sync_s nxt_st;

   always_comb
   begin
      nxt_st = st_ff;
      if (en_in)
      begin
         nxt_st.s1 = d_in;
         nxt_st.s2 = st_ff.s1;
         nxt_st.s3 = st_ff.s2;
         // a bit moves only when the last two stages agree
         nxt_st.q = (st_ff.s3 & ~(st_ff.s2 ^ st_ff.s3)) | (st_ff.q & (st_ff.s2 ^ st_ff.s3));
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         st_ff <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
      else
         st_ff <= nxt_st;
   end

   assign q_out = st_ff.q;
endmodule

// [core/serial_out_stage.sv]
// falling-edge output shifter for the serial output and the turned-around input pin
`timescale 1ns/1ps
module serial_out_stage (
   input wire logic sck_in,
   input wire logic link_rst_n_in,
   input wire logic active_in,
   input wire logic load_in,
   input wire logic dual_in,
   input wire logic [7:0] data_in,
   output logic so_out,
   output logic so_oe_out,
   output logic sio_out,
   output logic sio_oe_out
);
   typedef struct packed {
      logic [7:0] sh;
      logic so;
      logic so_oe;
      logic input_turned_output_pin;
      logic sio_oe;
   } tx_s;

   tx_s tx_ff;
   tx_s nxt_tx;
   logic [7:0] word;

   always_comb
   begin
      nxt_tx = tx_ff;
      word = load_in ? data_in : tx_ff.sh;
      nxt_tx.so_oe = active_in;
      nxt_tx.sio_oe = active_in & dual_in; // [R02]
      if (active_in)
      begin
         // msb leaves first; dual mode pairs bit 7 here with bit 6 on the other pin
         nxt_tx.so = word[7]; // [R04]
         nxt_tx.input_turned_output_pin = dual_in & word[6]; // [R16]
         nxt_tx.sh = dual_in ? {word[5:0], 2'b00} : {word[6:0], 1'b0};
      end
   end

   // changes on the falling edge; chip select release clears it at once
   always_ff @(negedge sck_in or negedge link_rst_n_in) // [R01] [R14]
   begin
      if (!link_rst_n_in)
         tx_ff <= '0;
      else
         tx_ff <= nxt_tx;
   end

   assign so_out = tx_ff.so;
   assign so_oe_out = tx_ff.so_oe;
   assign sio_out = tx_ff.input_turned_output_pin;
   assign sio_oe_out = tx_ff.sio_oe;
endmodule

// [verif/serial_flash_command_front_end_assertions.sv]
// port checker for the serial flash command front end
`timescale 1ns/1ps
module sflash_port_checker (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic sck_in,
   input wire logic cs_n_in,
   input wire logic serial_out_out,
   input wire logic serial_out_oe_out,
   input wire logic input_turned_output_pin_oe_out,
   input wire logic rd_en_out,
   input wire logic cmd_valid_out,
   input wire logic wr_valid_out,
   input wire logic frame_end_out
);
   logic hdr_seen_ff;
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_in);
   // ====
   // header seen in this frame
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         hdr_seen_ff <= 1'b0;
      else
         hdr_seen_ff <= cmd_valid_out | (hdr_seen_ff & ~frame_end_out);
   end
   // ====
   // assertions
   oe_release_a: assert property (cs_n_in |-> !serial_out_oe_out)
      else $error("serial output driven while deselected");
   pin_release_a: assert property (cs_n_in |-> !input_turned_output_pin_oe_out)
      else $error("turned pin driven while deselected");
   dual_pair_a: assert property (input_turned_output_pin_oe_out |-> serial_out_oe_out)
      else $error("turned pin driven alone");
   dual_phase_a: assert property (input_turned_output_pin_oe_out |-> rd_en_out)
      else $error("turned pin driven outside data phase");
   // sck is far slower than mclk, so two high samples mean no falling edge between
   fall_only_a: assert property (sck_in && $past(sck_in) && !cs_n_in && serial_out_oe_out
      |-> $stable(serial_out_out)) else $error("output changed while clock high");
   cmd_pulse_a: assert property (cmd_valid_out |=> !cmd_valid_out)
      else $error("command report longer than one cycle");
   frame_end_a: assert property ($rose(cs_n_in) |-> ##[1:8] frame_end_out)
      else $error("frame end not reported");
   wr_order_a: assert property (wr_valid_out |-> hdr_seen_ff)
      else $error("data byte before command header");
   cover property (cmd_valid_out);
   cover property (wr_valid_out);
   cover property (input_turned_output_pin_oe_out);
endmodule

bind serial_flash_command_front_end sflash_port_checker chk (
   .mclk_in(mclk_in), .rst_n_in(rst_n_in), .sck_in(sck_in), .cs_n_in(cs_n_in),
   .serial_out_out(serial_out_out), .serial_out_oe_out(serial_out_oe_out),
   .input_turned_output_pin_oe_out(input_turned_output_pin_oe_out), .rd_en_out(rd_en_out),
   .cmd_valid_out(cmd_valid_out), .wr_valid_out(wr_valid_out), .frame_end_out(frame_end_out)
);

// [verif/spi_host_model.sv]
// spi master model in mode 0 driving chip select, link clock and data lines
`timescale 1ns/1ps
module spi_host_model (
   output logic sck_out,
   output logic cs_n_out,
   output logic mosi_out,
   output logic dual_msb_out,
   input wire logic miso_in,
   input wire logic sio_in
);
   localparam real HALF = 62.5;
   initial
   begin
      sck_out = 1'b0;
      cs_n_out = 1'b1;
      mosi_out = 1'b1;
      dual_msb_out = 1'b0;
   end
   task automatic select();
      #HALF cs_n_out = 1'b0;
   endtask
   // released lines toggle so a stale level is never mistaken for data
   task automatic deselect();
      #HALF cs_n_out = 1'b1;
      mosi_out = ~mosi_out;
      dual_msb_out = ~dual_msb_out;
      #(2 * HALF);
   endtask
   // nclk clocks, msb first; dual moves two bits per clock
   task automatic xfer(input logic [7:0] tx, input logic dual, input int nclk,
                       output logic [7:0] rx);
      logic [7:0] sh;
      sh = tx;
      rx = 8'h00;
      repeat (nclk)
      begin
         dual_msb_out = dual ? sh[7] : ~dual_msb_out;
         mosi_out = dual ? sh[6] : sh[7];
         sh = dual ? {sh[5:0], 2'b00} : {sh[6:0], 1'b0};
         #HALF sck_out = 1'b1;
         rx = dual ? {rx[5:0], miso_in, sio_in} : {rx[6:0], miso_in};
         #HALF sck_out = 1'b0;
      end
   endtask
endmodule

// [verif/tb_serial_flash_command_front_end.sv]
// testbench for the serial flash command front end
`timescale 1ns/1ps
module tb_serial_flash_command_front_end;
   import sflash_pkg::*;
   localparam int LIMIT = 60000;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic sck, cs_n, mosi, output_turned_input_pin, so_w, sio_w;
   logic so, so_oe, input_turned_output_pin, sio_oe, rd_en, cmd_valid, wr_valid, frame_end, aligned;
   space_e rd_space;
   logic [ADDR_W-1:0] rd_addr, cmd_addr;
   logic [7:0] rd_data, cmd_opc, wr_data, rx;
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;
   int n_cmd = 0;
   int n_wr = 0;
   always #5 mclk = ~mclk;
   assign so_w = so_oe ? so : output_turned_input_pin;
   assign sio_w = sio_oe ? input_turned_output_pin : mosi;
   assign rd_data = rd_addr[7:0] ^ rd_addr[15:8] ^ 8'h5a ^ rd_space;
   spi_host_model host (.sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi), .dual_msb_out(output_turned_input_pin),
      .miso_in(so_w), .sio_in(sio_w));
   serial_flash_command_front_end DUT (.mclk_in(mclk), .rst_n_in(rst_n), .clk_en_in(clk_en),
      .sck_in(sck), .cs_n_in(cs_n), .serial_in_in(sio_w), .output_turned_input_pin_in(so_w),
      .serial_out_out(so), .serial_out_oe_out(so_oe), .input_turned_output_pin_out(input_turned_output_pin),
      .input_turned_output_pin_oe_out(sio_oe), .rd_en_out(rd_en), .rd_space_out(rd_space),
      .rd_addr_out(rd_addr), .rd_data_in(rd_data), .cmd_valid_out(cmd_valid),
      .cmd_opcode_out(cmd_opc), .cmd_addr_out(cmd_addr), .wr_valid_out(wr_valid),
      .wr_data_out(wr_data), .frame_end_out(frame_end), .frame_aligned_out(aligned));
   // ====
   // helpers
   function automatic logic [7:0] exp_b(input logic [ADDR_W-1:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      if (errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cycles++;
      n_cmd += (cmd_valid === 1'b1);
      n_wr += (wr_valid === 1'b1);
      if (cycles > LIMIT)
      begin
         errors++;
         test_done();
      end
   end
   task automatic hdr(input logic [7:0] opc, input logic [23:0] adr, input int na, input int nd);
      host.select();
      host.xfer(opc, 1'b0, 8, rx);
      for (int i = 0; i < na; i++)
         host.xfer(adr[23 - 8 * i -: 8], 1'b0, 8, rx);
      repeat (nd)
         host.xfer(8'h00, 1'b0, 8, rx);
   endtask
   task automatic close();
      host.deselect();
      repeat (12) @(posedge mclk);
   endtask
   // ====
   // scenarios
   task automatic t_reads();
      logic [7:0] ops [3] = '{8'h03, 8'h0b, 8'h1b};
      int n0;
      for (int i = 0; i < 3; i++)
      begin
         n0 = n_cmd;
         hdr(ops[i], 24'hc01230 + i, 3, i);
         for (int k = 0; k < 2; k++)
         begin
            host.xfer(8'h00, 1'b0, 8, rx);
            check("read byte", rx, exp_b(22'h001230 + i + k));
         end
         close();
         check("cmd count", n_cmd, n0 + 1);
         check("cmd opcode", cmd_opc, ops[i]);
         check("cmd addr", cmd_addr, 22'h001230 + i);
      end
      hdr(8'h03, 24'h3fffff, 3, 0);
      host.xfer(8'h00, 1'b0, 8, rx);
      check("last byte", rx, exp_b(22'h3fffff));
      host.xfer(8'h00, 1'b0, 8, rx);
      check("wrap byte", rx, exp_b(22'h000000));
      close();
   endtask
   task automatic t_dual();
      hdr(8'h3b, 24'h000100, 3, 1);
      host.xfer(8'h00, 1'b1, 4, rx);
      check("dual byte", rx, exp_b(22'h000100));
      check("dual pin oe", sio_oe, 1'b1);
      host.xfer(8'h00, 1'b1, 4, rx);
      check("dual next", rx, exp_b(22'h000101));
      close();
      check("dual release", {so_oe, sio_oe}, 2'b00);
   endtask
   task automatic t_prog();
      int n0;
      for (int d = 0; d < 2; d++)
      begin
         n0 = n_wr;
         hdr(d ? 8'ha2 : 8'h02, 24'h000040, 3, 0);
         host.xfer(8'h96 + d, d, d ? 4 : 8, rx);
         close();
         check("prog opcode", cmd_opc, d ? 8'ha2 : 8'h02);
         check("prog count", n_wr, n0 + 1);
         check("prog data", wr_data, 8'h96 + d);
         check("prog aligned", aligned, 1'b1);
      end
   endtask
   task automatic t_ops();
      logic [7:0] ops [11] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'hb0, 8'hd0, 8'h06, 8'h04,
         8'hb9, 8'hab};
      int n0;
      int n1;
      for (int i = 0; i < 11; i++)
      begin
         n0 = n_cmd;
         n1 = n_wr;
         hdr(ops[i], 24'h012345, i < 3 ? 3 : 0, 0);
         if (i >= 3)
            host.xfer(8'h5a, 1'b0, 8, rx);
         close();
         check("op count", n_cmd, n0 + 1);
         check("op code", cmd_opc, ops[i]);
         check("op addr", cmd_addr, i < 3 ? 22'h012345 : 22'h000000);
         check("op extra", n_wr, n1);
      end
   endtask
   task automatic t_refuse();
      int n0;
      int n1;
      n0 = n_cmd;
      n1 = n_wr;
      hdr(8'hff, 24'h030000, 3, 1);
      close();
      hdr(8'h02, 24'h000040, 2, 0);
      close();
      check("ignored cmds", n_cmd, n0);
      check("ignored data", n_wr, n1);
      hdr(8'h03, 24'h000000, 3, 0);
      host.xfer(8'h00, 1'b0, 3, rx);
      check("mid read oe", so_oe, 1'b1);
      host.deselect();
      check("abort oe", so_oe, 1'b0);
      repeat (12) @(posedge mclk);
      n1 = n_wr;
      hdr(8'h01, 24'h000000, 0, 0);
      host.xfer(8'h3c, 1'b0, 8, rx);
      host.xfer(8'hc3, 1'b0, 8, rx);
      close();
      check("one byte", n_wr, n1 + 1);
      hdr(8'h9f, 24'h000000, 0, 0);
      host.xfer(8'h00, 1'b0, 8, rx);
      check("id byte", rx, 8'h5a ^ SPACE_ID);
      repeat (4)
         host.xfer(8'h00, 1'b0, 8, rx);
      check("id stop", so_oe, 1'b0);
      close();
   endtask
   initial
   begin
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      t_reads();
      t_dual();
      t_prog();
      t_ops();
      t_refuse();
      test_done();
   end
endmodule
